// file: common/trc_pkg.sv
// Package with command codes, field layouts and timing counts for the telemetry/config register bank
package trc_pkg;

	// ==================================================
	// Command codes
	localparam logic [7:0] CMD_INPUT_VOLTAGE   = 8'h88;
	localparam logic [7:0] CMD_INPUT_CURRENT   = 8'h89;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE  = 8'h8B;
	localparam logic [7:0] CMD_OUTPUT_CURRENT  = 8'h8C;
	localparam logic [7:0] CMD_DIE_TEMPERATURE = 8'h8D;
	localparam logic [7:0] CMD_INPUT_POWER     = 8'h97;
	localparam logic [7:0] CMD_MISC_CONFIG     = 8'hA0;
	localparam logic [7:0] CMD_STORE_ALL       = 8'h15;

	// ==================================================
	// Configuration field positions
	localparam int CFG_CONDUCTION_BIT = 7;
	localparam int CFG_VCTRL_HI       = 6;
	localparam int CFG_VCTRL_LO       = 5;
	localparam int CFG_SOFT_STOP_BIT  = 4;
	localparam int CFG_PGOOD_HI       = 3;
	localparam int CFG_PGOOD_LO       = 2;
	localparam int CFG_VID_ADDR_BIT   = 1;
	localparam int CFG_BUS_ADDR_BIT   = 0;

	// Voltage-control source encodings
	localparam logic [1:0] VCTRL_ALL_LINK   = 2'h0;
	localparam logic [1:0] VCTRL_OFFSET_BUS = 2'h1;

	// ==================================================
	// Timing
	localparam int CLOCK_MHZ       = 100;
	localparam int FAST_REFRESH_US = 95;
	localparam int SLOW_REFRESH_US = 190;
	localparam int FAST_REFRESH_CYC = FAST_REFRESH_US * CLOCK_MHZ;
	localparam int SLOW_REFRESH_CYC = SLOW_REFRESH_US * CLOCK_MHZ;
	localparam int PGOOD_HALF_MS_US = 500;
	localparam int PGOOD_ONE_MS_US  = 1000;
	localparam int PGOOD_TWO_MS_US  = 2000;
	localparam int PGOOD_HALF_CYC   = PGOOD_HALF_MS_US * CLOCK_MHZ;
	localparam int PGOOD_ONE_CYC    = PGOOD_ONE_MS_US * CLOCK_MHZ;
	localparam int PGOOD_TWO_CYC    = PGOOD_TWO_MS_US * CLOCK_MHZ;
	localparam logic [7:0] CONFIG_RESET = 8'h00;

	// ==================================================
	// Carriers
	typedef struct packed {
		logic [7:0] input_voltage;
		logic [7:0] input_current;
		logic [7:0] output_voltage;
		logic [7:0] output_current;
		logic [7:0] die_temperature;
		logic [7:0] input_power;
	} trc_samples_t;

	typedef struct packed {
		logic       forced_continuous;
		logic       volt_from_bus;
		logic       offset_from_bus;
		logic       soft_stop_enable;
		logic [1:0] power_good_delay;
		logic       vid_link_address_override;
		logic       bus_address_override;
	} trc_config_t;

endpackage : trc_pkg

// file: rtl/trc_refresh_timer.sv
// Free-running refresh tick generator
`timescale 1ns/1ns
`default_nettype none

module trc_refresh_timer #(
	parameter int PERIOD = 9500
) (
	input  wire logic i_clock,
	input  wire logic i_rst,
	output logic      o_tick
);

	logic [31:0] count;

	// Count up; tick on wrap
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			count <= 32'h0000_0000;
		end else if (count == 32'(PERIOD - 1)) begin
			count <= 32'h0000_0000;
		end else begin
			count <= count + 32'h0000_0001;
		end
	end

	assign o_tick = (count == 32'(PERIOD - 1));

endmodule : trc_refresh_timer

`default_nettype wire

// file: rtl/trc_regs.sv
// Telemetry readback and miscellaneous configuration register bank
`timescale 1ns/1ns
`default_nettype none

module trc_regs (
	input  wire logic                  i_clock,
	input  wire logic                  i_rst,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	input  wire logic [7:0]            i_cmd,
	input  wire logic [7:0]            i_wdata,
	output logic      [7:0]            o_rdata,
	output logic                       o_rvalid,
	output logic                       o_nack,
	input  wire trc_pkg::trc_samples_t i_samples,
	input  wire logic                  i_vout_fine_range,
	input  wire logic                  i_switching_enabled,
	input  wire logic                  i_supply_reset_done,
	input  wire logic                  i_soft_start_done,
	output trc_pkg::trc_config_t       o_config,
	output logic                       o_vout_fine_step,
	output logic                       o_store_request,
	output logic                       o_power_good_output,
	output logic                       o_apply_turn_off_delay
);

	// ==================================================
	// Refresh ticks
	logic fast_tick;
	logic slow_tick;

	trc_refresh_timer #(.PERIOD(trc_pkg::FAST_REFRESH_CYC)) u_fast (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.o_tick  (fast_tick)
	);

	trc_refresh_timer #(.PERIOD(trc_pkg::SLOW_REFRESH_CYC)) u_slow (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.o_tick  (slow_tick)
	);

	// ==================================================
	// Sample latches: held between ticks so reads see a completed sample
	trc_pkg::trc_samples_t held;
	logic                  fine_step;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			held      <= '0;
			fine_step <= 1'b1;
		end else begin
			if (fast_tick) begin
				held.input_current  <= i_samples.input_current;
				held.output_current <= i_samples.output_current;
				held.input_power    <= i_samples.input_power;
			end
			if (slow_tick) begin
				held.input_voltage   <= i_samples.input_voltage;
				held.output_voltage  <= i_samples.output_voltage;
				held.die_temperature <= i_samples.die_temperature;
				fine_step            <= i_vout_fine_range;
			end
		end
	end

	assign o_vout_fine_step = fine_step;

	// ==================================================
	// Configuration byte, written on the fly
	logic [7:0] cfg_live;
	logic [7:0] cfg_active;
	logic [7:0] cfg_boot;
	logic       wr_cfg;
	logic       wr_store;

	assign wr_cfg   = i_wr && (i_cmd == trc_pkg::CMD_MISC_CONFIG);
	assign wr_store = i_wr && (i_cmd == trc_pkg::CMD_STORE_ALL);

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cfg_live <= trc_pkg::CONFIG_RESET;
		end else if (wr_cfg) begin
			cfg_live <= i_wdata;
		end
	end

	// Fields that act only while switching is off follow the live byte when idle
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cfg_active <= trc_pkg::CONFIG_RESET;
		end else if (!i_switching_enabled) begin
			cfg_active <= cfg_live;
		end
	end

	// Override bits take effect only after a store then a supply reset
	logic [1:0] stored_ovrd;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			stored_ovrd <= 2'h0;
			cfg_boot    <= trc_pkg::CONFIG_RESET;
		end else begin
			if (wr_store) begin
				stored_ovrd <= cfg_live[trc_pkg::CFG_VID_ADDR_BIT:trc_pkg::CFG_BUS_ADDR_BIT];
			end
			if (i_supply_reset_done) begin
				cfg_boot[1:0] <= stored_ovrd;
			end
		end
	end

	assign o_store_request = wr_store;

	// ==================================================
	// Decoded configuration
	logic [1:0] vctrl;
	assign vctrl = cfg_active[trc_pkg::CFG_VCTRL_HI:trc_pkg::CFG_VCTRL_LO];

	assign o_config.forced_continuous = cfg_active[trc_pkg::CFG_CONDUCTION_BIT];
	assign o_config.volt_from_bus = (vctrl != trc_pkg::VCTRL_ALL_LINK) &&
		(vctrl != trc_pkg::VCTRL_OFFSET_BUS);
	assign o_config.offset_from_bus = (vctrl != trc_pkg::VCTRL_ALL_LINK);
	assign o_config.soft_stop_enable = cfg_active[trc_pkg::CFG_SOFT_STOP_BIT];
	assign o_config.power_good_delay = cfg_active[trc_pkg::CFG_PGOOD_HI:trc_pkg::CFG_PGOOD_LO];
	assign o_config.vid_link_address_override = cfg_boot[trc_pkg::CFG_VID_ADDR_BIT];
	assign o_config.bus_address_override = cfg_boot[trc_pkg::CFG_BUS_ADDR_BIT];

	// Soft stop off forces zero turn-off delay
	assign o_apply_turn_off_delay = cfg_active[trc_pkg::CFG_SOFT_STOP_BIT];

	// ==================================================
	// Power-good delay counter
	logic [31:0] pg_count;
	logic [31:0] pg_target;
	logic        pg;

	function automatic logic [31:0] pg_cycles(input logic [1:0] code);
		unique case (code)
			2'h0: pg_cycles = 32'h0000_0000;
			2'h1: pg_cycles = 32'(trc_pkg::PGOOD_HALF_CYC);
			2'h2: pg_cycles = 32'(trc_pkg::PGOOD_ONE_CYC);
			2'h3: pg_cycles = 32'(trc_pkg::PGOOD_TWO_CYC);
		endcase
	endfunction : pg_cycles

	assign pg_target = pg_cycles(o_config.power_good_delay);

	// Counts from soft-start done; a drop of soft-start done restarts it
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pg_count <= 32'h0000_0000;
			pg       <= 1'b0;
		end else if (!i_soft_start_done) begin
			pg_count <= 32'h0000_0000;
			pg       <= 1'b0;
		end else if (pg_count >= pg_target) begin
			pg <= 1'b1;
		end else begin
			pg_count <= pg_count + 32'h0000_0001;
		end
	end

	assign o_power_good_output = pg;

	// ==================================================
	// Read decode; reads touch no state besides the answer
	logic [7:0] next_rdata;
	logic       cmd_known;

	always_comb begin
		next_rdata = 8'h00;
		cmd_known  = 1'b1;
		unique case (i_cmd)
			trc_pkg::CMD_INPUT_VOLTAGE:   next_rdata = held.input_voltage;
			trc_pkg::CMD_INPUT_CURRENT:   next_rdata = held.input_current;
			trc_pkg::CMD_OUTPUT_VOLTAGE:  next_rdata = held.output_voltage;
			trc_pkg::CMD_OUTPUT_CURRENT:  next_rdata = held.output_current;
			trc_pkg::CMD_DIE_TEMPERATURE: next_rdata = held.die_temperature;
			trc_pkg::CMD_INPUT_POWER:     next_rdata = held.input_power;
			trc_pkg::CMD_MISC_CONFIG:     next_rdata = cfg_live;
			default:                      cmd_known  = 1'b0;
		endcase
	end

	// Writes to telemetry codes have no transaction and are refused
	logic wr_bad;
	assign wr_bad = i_wr && !wr_cfg && !wr_store;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rdata  <= 8'h00;
			o_rvalid <= 1'b0;
			o_nack   <= 1'b0;
		end else begin
			o_rvalid <= i_rd && cmd_known;
			o_nack   <= (i_rd && !cmd_known) || wr_bad;
			if (i_rd) begin
				o_rdata <= next_rdata;
			end
		end
	end

	// ==================================================
	// Checks
	AST_READ_CURRENT: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_cmd == trc_pkg::CMD_INPUT_CURRENT) |=> (o_rvalid && o_rdata == $past(held.input_current)))
		else $error("input current read wrong");
	AST_READ_VOUT: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_cmd == trc_pkg::CMD_OUTPUT_VOLTAGE) |=> (o_rdata == $past(held.output_voltage)))
		else $error("output voltage read wrong");
	AST_FAST_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
		!fast_tick |=> $stable(held.output_current))
		else $error("output current changed between refreshes");
	AST_SLOW_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
		!slow_tick |=> $stable(held.die_temperature))
		else $error("temperature changed between refreshes");
	AST_POWER_LOAD: assert property (@(posedge i_clock) disable iff (i_rst)
		fast_tick |=> (held.input_power == $past(i_samples.input_power)))
		else $error("input power not loaded on refresh");
	AST_CFG_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
		wr_cfg ##1 !i_wr ##1 (i_rd && i_cmd == trc_pkg::CMD_MISC_CONFIG && !i_wr) |=>
		(o_rdata == $past(i_wdata, 3)))
		else $error("config write not read back");
	AST_TELEM_NACK: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_wr && (i_cmd == trc_pkg::CMD_INPUT_POWER || i_cmd == trc_pkg::CMD_INPUT_CURRENT ||
		i_cmd == trc_pkg::CMD_OUTPUT_CURRENT)) |=> o_nack)
		else $error("telemetry write not refused");
	AST_PG_ZERO: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_soft_start_done && pg_target == 32'h0000_0000 && !pg) |=> pg)
		else $error("zero power-good delay not immediate");
	AST_PG_LOW: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_soft_start_done |=> !pg)
		else $error("power good high without soft start");
	AST_SOFT_STOP: assert property (@(posedge i_clock) disable iff (i_rst)
		(wr_cfg && !i_switching_enabled) ##1 !i_switching_enabled |=>
		(o_apply_turn_off_delay == $past(i_wdata[trc_pkg::CFG_SOFT_STOP_BIT], 2)))
		else $error("turn-off delay does not follow soft stop");
	AST_VCTRL: assert property (@(posedge i_clock) disable iff (i_rst)
		(vctrl == trc_pkg::VCTRL_ALL_LINK) |-> (!o_config.offset_from_bus && !o_config.volt_from_bus))
		else $error("link source decode wrong");

	// Every telemetry code answers with its held byte; loads and holds follow the ticks only
	AST_INPUT_VOLTAGE_READING: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_cmd == trc_pkg::CMD_INPUT_VOLTAGE) |=> (o_rvalid && o_rdata == $past(held.input_voltage)))
		else $error("input voltage read wrong");
	AST_OUTPUT_CURRENT_READING: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_cmd == trc_pkg::CMD_OUTPUT_CURRENT) |=> (o_rvalid && o_rdata == $past(held.output_current)))
		else $error("output current read wrong");
	AST_READ_TEMP: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_cmd == trc_pkg::CMD_DIE_TEMPERATURE) |=> (o_rvalid && o_rdata == $past(held.die_temperature)))
		else $error("temperature read wrong");
	AST_READ_PIN: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_cmd == trc_pkg::CMD_INPUT_POWER) |=> (o_rvalid && o_rdata == $past(held.input_power)))
		else $error("input power read wrong");
	AST_UNKNOWN_NACK: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_rd && !cmd_known) |=> (o_nack && !o_rvalid && o_rdata == 8'h00))
		else $error("unknown read not refused");
	AST_CFG_NO_NACK: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_wr && i_cmd == trc_pkg::CMD_MISC_CONFIG) |=> !o_nack)
		else $error("config write refused");
	AST_RVALID_PULSE: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_rd |=> !o_rvalid)
		else $error("read answer without a read");
	AST_IIN_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
		!fast_tick |=> $stable(held.input_current))
		else $error("input current changed between refreshes");
	AST_VOUT_LOAD: assert property (@(posedge i_clock) disable iff (i_rst)
		slow_tick |=> (held.output_voltage == $past(i_samples.output_voltage)))
		else $error("output voltage not loaded on refresh");
	AST_VIN_LOAD: assert property (@(posedge i_clock) disable iff (i_rst)
		slow_tick |=> (held.input_voltage == $past(i_samples.input_voltage)))
		else $error("input voltage not loaded on refresh");
	AST_FINE_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
		!slow_tick |=> $stable(fine_step))
		else $error("step range changed between refreshes");
	AST_IDLE_ONLY: assert property (@(posedge i_clock) disable iff (i_rst)
		i_switching_enabled |=> $stable(cfg_active))
		else $error("config fields acted while switching");
	AST_OVRD_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_supply_reset_done |=> $stable(cfg_boot[1:0]))
		else $error("override bits acted without supply reset");
	AST_PG_STAY: assert property (@(posedge i_clock) disable iff (i_rst)
		(pg && i_soft_start_done) |=> pg)
		else $error("power good dropped during soft start done");

endmodule : trc_regs

`default_nettype wire

// file: sim/trc_host_model.sv
// Host-side model issuing single-byte reads and writes on the command strobes
`timescale 1ns/1ns
`default_nettype none

module trc_host_model (
	input  wire logic       i_clock,
	output logic            o_wr,
	output logic            o_rd,
	output logic [7:0]      o_cmd,
	output logic [7:0]      o_wdata,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rvalid,
	input  wire logic       i_nack,
	input  wire logic       i_store
);
	// ==================================================
	// Idle bus at time zero
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_cmd = 8'h00;
		o_wdata = 8'h00;
	end

	// ==================================================
	// One-cycle strobe; the answer is taken one cycle after the request edge
	task automatic access(input logic wr, input logic [7:0] cmd, input logic [7:0] data,
		output logic [7:0] rdat, output logic rvl, output logic nak, output logic stq);
		@(posedge i_clock);
		o_wr <= wr;
		o_rd <= !wr;
		o_cmd <= cmd;
		o_wdata <= data;
		#1 stq = i_store;
		@(posedge i_clock);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_cmd <= ~cmd; // Released lines flip so stale values never look valid
		o_wdata <= ~data;
		#1 rdat = i_rdata;
		rvl = i_rvalid;
		nak = i_nack;
	endtask : access
endmodule : trc_host_model
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the telemetry and configuration register bank
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic                  i_clock;
	logic                  i_rst;
	logic                  wr;
	logic                  rd;
	logic [7:0]            cmd;
	logic [7:0]            wdata;
	logic [7:0]            rdata;
	logic                  rvalid;
	logic                  nack;
	trc_pkg::trc_samples_t smp;
	logic                  fine;
	logic                  sw_en;
	logic                  sup_rst;
	logic                  ss_done;
	trc_pkg::trc_config_t  cfg;
	logic                  fine_step;
	logic                  store;
	logic                  pgood;
	logic                  toff;
	logic [7:0]            rdat;
	logic                  rvl;
	logic                  nak;
	logic                  stq;
	logic [7:0]            codes [6];
	int                    bad_count;
	int                    n_checks;
	int                    n;

	// ==================================================
	// Design and host
	trc_regs u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_wr(wr), .i_rd(rd), .i_cmd(cmd),
		.i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .o_nack(nack), .i_samples(smp),
		.i_vout_fine_range(fine), .i_switching_enabled(sw_en), .i_supply_reset_done(sup_rst),
		.i_soft_start_done(ss_done), .o_config(cfg), .o_vout_fine_step(fine_step),
		.o_store_request(store), .o_power_good_output(pgood), .o_apply_turn_off_delay(toff));
	trc_host_model u_host (.i_clock(i_clock), .o_wr(wr), .o_rd(rd), .o_cmd(cmd), .o_wdata(wdata),
		.i_rdata(rdata), .i_rvalid(rvalid), .i_nack(nack), .i_store(store));

	// ==================================================
	// Shared tasks
	task automatic give_verdict();
		if (bad_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic acc(input logic w, input logic [7:0] c, input logic [7:0] d);
		u_host.access(w, c, d, rdat, rvl, nak, stq);
	endtask : acc

	// Codes follow the sample struct order, so slot i sits at bits 47-8i
	task automatic rd_all(input trc_pkg::trc_samples_t s);
		for (int i = 0; i < 6; i++) begin
			acc(1'b0, codes[i], 8'h00);
			check("telemetry", 16'({rvl, rdat}), 16'({1'b1, s[47 - 8 * i -: 8]}));
		end
	endtask : rd_all

	// Bounded wait for power good, counting cycles
	task automatic wait_pg(input int lim);
		n = 0;
		while (pgood !== 1'b1) begin
			@(posedge i_clock);
			#1; // Look once the edge has settled, never in its own time step
			n++;
			if (n > lim) begin
				bad_count++;
				give_verdict();
			end
		end
	endtask : wait_pg

	// ==================================================
	// Clock
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	// ==================================================
	// Main sequence
	initial begin
		codes = '{trc_pkg::CMD_INPUT_VOLTAGE, trc_pkg::CMD_INPUT_CURRENT, trc_pkg::CMD_OUTPUT_VOLTAGE,
			trc_pkg::CMD_OUTPUT_CURRENT, trc_pkg::CMD_DIE_TEMPERATURE, trc_pkg::CMD_INPUT_POWER};
		bad_count = 0;
		n_checks = 0;
		i_rst = 1'b1;
		smp = '0;
		fine = 1'b1;
		sw_en = 1'b1;
		sup_rst = 1'b0;
		ss_done = 1'b0;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		// Nothing sampled yet, so every reading is the cleared hold value
		rd_all('0);
		acc(1'b0, trc_pkg::CMD_MISC_CONFIG, 8'h00);
		check("cfg_reset", 16'(rdat), 16'h0000);
		check("fine_pg_reset", 16'({fine_step, pgood}), 16'h0002);
		// Refusals
		acc(1'b0, 8'h8A, 8'h00);
		check("unknown_rd", 16'({rvl, nak, rdat}), 16'h0100);
		acc(1'b1, trc_pkg::CMD_INPUT_CURRENT, 8'h5A);
		check("tlm_wr_nack", 16'(nak), 16'h0001);
		// Written while switching: readable at once, not yet acting
		acc(1'b1, trc_pkg::CMD_MISC_CONFIG, 8'hFC);
		check("cfg_wr_ack", 16'(nak), 16'h0000);
		acc(1'b0, trc_pkg::CMD_MISC_CONFIG, 8'h00);
		check("cfg_live", 16'({rdat, cfg}), 16'hFC00);
		sw_en <= 1'b0;
		// Every control-source code, conduction mode and soft-stop value
		for (int s = 0; s < 4; s++) begin
			acc(1'b1, trc_pkg::CMD_MISC_CONFIG, {s[0], s[1:0], s[1], 4'h3});
			repeat (2) @(posedge i_clock);
			check("cfg_fields", 16'(cfg), 16'({s[0], s[1], |s[1:0], s[1], 4'h0}));
			check("soft_stop", 16'(toff), 16'(s[1]));
		end
		// Overrides act only after store-all and a supply reset
		acc(1'b1, trc_pkg::CMD_STORE_ALL, 8'h00);
		check("store_req", 16'({stq, cfg[1:0]}), 16'h0004);
		@(posedge i_clock);
		sup_rst <= 1'b1;
		@(posedge i_clock);
		sup_rst <= 1'b0;
		repeat (2) @(posedge i_clock);
		check("overrides", 16'(cfg[1:0]), 16'h0003);
		// Samples land on the ticks; later input changes stay unseen until the next tick
		smp <= 48'hA1B2_C3D4_E5F6;
		fine <= 1'b0;
		// Before the first tick nothing moves; after it only the fast group has loaded
		repeat (9400) @(posedge i_clock);
		rd_all('0);
		repeat (100) @(posedge i_clock);
		rd_all(48'h00B2_00D4_00F6);
		repeat (9576) @(posedge i_clock);
		smp <= 48'h1122_3344_5566;
		rd_all(48'hA1B2_C3D4_E5F6);
		check("fine_step", 16'(fine_step), 16'h0000);
		acc(1'b1, trc_pkg::CMD_OUTPUT_CURRENT, 8'h00);
		check("iout_wr_nack", 16'(nak), 16'h0001);
		rd_all(48'hA1B2_C3D4_E5F6);
		// Zero delay code: power good follows soft start
		ss_done <= 1'b1;
		wait_pg(8);
		check("pg_zero", 16'(n <= 4), 16'h0001);
		// Second reset, then the half-millisecond code
		i_rst <= 1'b1;
		ss_done <= 1'b0;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		acc(1'b1, trc_pkg::CMD_MISC_CONFIG, 8'h04);
		@(posedge i_clock);
		ss_done <= 1'b1;
		wait_pg(60000);
		check("pg_half", 16'(n >= trc_pkg::PGOOD_HALF_CYC && n <= trc_pkg::PGOOD_HALF_CYC + 2), 16'h0001);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
